// ### logic/tcmp_pkg.sv
// Notes on behaviour
// - interval mode: period compare sets counter match
// - pulse mode: period compare sets output period
// - interlocked second unit ignores own period compare
// - edge compares double-buffered behind timer registers
// - compares read-only; software writes buffers only
// - interval mode: compare 1 match raises interrupt
// - interval mode: compare 2 match raises interrupt
// - pulse mode: compare 1 gives leading edge
// - pulse mode: compare 2 gives trailing edge
// - transfer only while load flag set; then cleared
package tcmp_pkg;
    localparam logic [7:0] PERIOD_BUF_OFS = 8'h00;
    localparam logic [7:0] PERIOD_CMP_OFS = 8'h04;
    localparam logic [7:0] EDGE1_BUF_OFS = 8'h08;
    localparam logic [7:0] EDGE1_CMP_OFS = 8'h0c;
    localparam logic [7:0] EDGE2_BUF_OFS = 8'h10;
    localparam logic [7:0] EDGE2_CMP_OFS = 8'h14;
    localparam logic [7:0] CONTROL_OFS = 8'h18;
    localparam logic [7:0] LOAD_OFS = 8'h1c;
    localparam logic [7:0] STATUS_OFS = 8'h20;
    localparam logic [7:0] MASK_OFS = 8'h24;
    localparam logic [7:0] COUNT_OFS = 8'h28;
    // control fields
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_PULSE_BIT = 1;
    localparam int CTL_INTERLOCK_BIT = 2;
    localparam int CTL_SECOND_BIT = 3;
    localparam int LOAD_BIT = 0;
    // status fields
    localparam int ST_PERIOD_BIT = 0;
    localparam int ST_CMP1_BIT = 1;
    localparam int ST_CMP2_BIT = 2;
    localparam logic [15:0] VAL_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tcmp_pkg

// ### logic/timer_compare_double_buffer.sv
module timer_compare_double_buffer (
    input wire logic I_SYS_CLK,
    input wire logic I_SRST,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic O_FIRST_OUTPUT_PAIR,
    output logic O_IRQ
);
    // ****************************************
    // bus slave
    // ****************************************
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_word;

    // one write at a time: take address and data in any order, answer after both
    assign wr_go = aw_have_q && w_have_q && !O_BVALID;

    // readies drop after a take and stay low until the held write goes out, so a held valid is never taken twice
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            O_AWREADY <= 1'b0;
        end else begin
            O_AWREADY <= !aw_have_q && !(I_AWVALID && O_AWREADY);
            if (I_AWVALID && O_AWREADY) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= I_AWADDR;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            O_WREADY <= 1'b0;
        end else begin
            O_WREADY <= !w_have_q && !(I_WVALID && O_WREADY);
            if (I_WVALID && O_WREADY) begin
                w_have_q <= 1'b1;
                w_data_q <= I_WDATA;
                w_strb_q <= I_WSTRB;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            O_BVALID <= 1'b0;
            O_BRESP <= 2'b00;
        end else if (wr_go) begin
            O_BVALID <= 1'b1;
            O_BRESP <= wr_ok ? tcmp_pkg::RESP_OKAY : tcmp_pkg::RESP_SLVERR;
        end else if (O_BVALID && I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] period_buffer_value_q;
    logic [15:0] period_compare_value_q;
    logic [15:0] edge1_buffer_value_q;
    logic [15:0] edge1_compare_value_q;
    logic [15:0] edge2_buffer_value_q;
    logic [15:0] edge2_compare_value_q;
    logic [3:0] control_q;
    logic load_enable_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [15:0] count_q;
    logic [15:0] wr_half;
    logic load_set;
    logic [2:0] events;

    // data bits 31..16 and strobes 3..2 are dropped: no field is wider than sixteen bits
    assign wr_half = {w_strb_q[1] ? w_data_q[15:8] : 8'h00, w_strb_q[0] ? w_data_q[7:0] : 8'h00};
    assign load_set = wr_go && aw_addr_q == tcmp_pkg::LOAD_OFS && w_strb_q[0]
        && w_data_q[tcmp_pkg::LOAD_BIT];

    always_comb begin
        case (aw_addr_q)
            tcmp_pkg::PERIOD_BUF_OFS, tcmp_pkg::EDGE1_BUF_OFS, tcmp_pkg::EDGE2_BUF_OFS,
            tcmp_pkg::CONTROL_OFS, tcmp_pkg::LOAD_OFS, tcmp_pkg::STATUS_OFS,
            tcmp_pkg::MASK_OFS: wr_ok = 1'b1;
            default: wr_ok = 1'b0; // compares and count are read-only
        endcase
    end

    function automatic logic [15:0] merge(input logic [15:0] old);
        merge = {w_strb_q[1] ? wr_half[15:8] : old[15:8], w_strb_q[0] ? wr_half[7:0] : old[7:0]};
    endfunction : merge

    // buffers: partial strobes merge with old value, upper half dropped
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            period_buffer_value_q <= tcmp_pkg::VAL_RESET;
            edge1_buffer_value_q <= tcmp_pkg::VAL_RESET;
            edge2_buffer_value_q <= tcmp_pkg::VAL_RESET;
        end else if (wr_go) begin
            case (aw_addr_q)
                tcmp_pkg::PERIOD_BUF_OFS: begin
                    period_buffer_value_q <= merge(period_buffer_value_q);
                end
                tcmp_pkg::EDGE1_BUF_OFS: begin
                    edge1_buffer_value_q <= merge(edge1_buffer_value_q);
                end
                tcmp_pkg::EDGE2_BUF_OFS: begin
                    edge2_buffer_value_q <= merge(edge2_buffer_value_q);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            control_q <= 4'h0;
        end else if (wr_go && w_strb_q[0] && aw_addr_q == tcmp_pkg::CONTROL_OFS) begin
            control_q <= w_data_q[3:0];
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            mask_q <= 3'h0;
        end else if (wr_go && w_strb_q[0] && aw_addr_q == tcmp_pkg::MASK_OFS) begin
            mask_q <= w_data_q[2:0];
        end
    end

    // ****************************************
    // compare transfer
    // ****************************************
    logic transfer;
    logic run;
    logic pulse_mode;
    logic period_ignored;
    logic period_match;

    assign run = control_q[tcmp_pkg::CTL_RUN_BIT];
    assign pulse_mode = control_q[tcmp_pkg::CTL_PULSE_BIT];
    // interlocked second unit has no period of its own
    assign period_ignored = control_q[tcmp_pkg::CTL_INTERLOCK_BIT]
        && control_q[tcmp_pkg::CTL_SECOND_BIT];
    // copy at counter restart while running, or at once while stopped
    // an interlocked second unit never restarts, so its load waits for a stop
    assign transfer = load_enable_q && (!run || period_match);

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            load_enable_q <= 1'b0;
        end else if (load_set) begin
            load_enable_q <= 1'b1; // a new set wins over the clear
        end else if (transfer) begin
            load_enable_q <= 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            period_compare_value_q <= tcmp_pkg::VAL_RESET;
            edge1_compare_value_q <= tcmp_pkg::VAL_RESET;
            edge2_compare_value_q <= tcmp_pkg::VAL_RESET;
        end else if (transfer) begin
            period_compare_value_q <= period_buffer_value_q;
            edge1_compare_value_q <= edge1_buffer_value_q;
            edge2_compare_value_q <= edge2_buffer_value_q;
        end
    end

    // ****************************************
    // counter and matches
    // ****************************************
    // a zero period matches every cycle; software keeps it nonzero
    assign period_match = run && !period_ignored
        && count_q == period_compare_value_q;

    // without a period match the count wraps through the full sixteen bits
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST || !run) begin
            count_q <= 16'h0000;
        end else if (period_match) begin
            count_q <= 16'h0000;
        end else begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign events[tcmp_pkg::ST_PERIOD_BIT] = period_match;
    // edge matches are interrupt events only in interval mode
    assign events[tcmp_pkg::ST_CMP1_BIT] = run && !pulse_mode
        && count_q == edge1_compare_value_q;
    assign events[tcmp_pkg::ST_CMP2_BIT] = run && !pulse_mode
        && count_q == edge2_compare_value_q;

    // ****************************************
    // pulse output and interrupt
    // ****************************************
    // both edges show one cycle after their compare; trailing wins a tie
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST || !run || !pulse_mode) begin
            O_FIRST_OUTPUT_PAIR <= 1'b0;
        end else if (count_q == edge2_compare_value_q) begin
            O_FIRST_OUTPUT_PAIR <= 1'b0;
        end else if (count_q == edge1_compare_value_q) begin
            O_FIRST_OUTPUT_PAIR <= 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            status_q <= 3'h0;
        end else if (wr_go && aw_addr_q == tcmp_pkg::STATUS_OFS && w_strb_q[0]) begin
            status_q <= (status_q & ~w_data_q[2:0]) | events; // set beats clear
        end else begin
            status_q <= status_q | events;
        end
    end

    // one register stage from status to pin keeps the output a plain flip-flop
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(status_q & mask_q);
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    always_comb begin
        rd_ok = 1'b1;
        case (I_ARADDR)
            tcmp_pkg::PERIOD_BUF_OFS: rd_word = {16'h0000, period_buffer_value_q};
            tcmp_pkg::PERIOD_CMP_OFS: rd_word = {16'h0000, period_compare_value_q};
            tcmp_pkg::EDGE1_BUF_OFS: rd_word = {16'h0000, edge1_buffer_value_q};
            tcmp_pkg::EDGE1_CMP_OFS: rd_word = {16'h0000, edge1_compare_value_q};
            tcmp_pkg::EDGE2_BUF_OFS: rd_word = {16'h0000, edge2_buffer_value_q};
            tcmp_pkg::EDGE2_CMP_OFS: rd_word = {16'h0000, edge2_compare_value_q};
            tcmp_pkg::CONTROL_OFS: rd_word = {28'h0000000, control_q};
            tcmp_pkg::LOAD_OFS: rd_word = {31'h00000000, load_enable_q};
            tcmp_pkg::STATUS_OFS: rd_word = {29'h00000000, status_q};
            tcmp_pkg::MASK_OFS: rd_word = {29'h00000000, mask_q};
            tcmp_pkg::COUNT_OFS: rd_word = {16'h0000, count_q};
            default: begin
                rd_word = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= 2'b00;
        end else begin
            // word caught at the take; answer stands until the master takes it
            O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_word;
                O_RRESP <= rd_ok ? tcmp_pkg::RESP_OKAY : tcmp_pkg::RESP_SLVERR;
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end
endmodule : timer_compare_double_buffer

// ### verif/timer_compare_double_buffer_checker.sv
module timer_compare_double_buffer_checker (
    input wire logic I_SYS_CLK,
    input wire logic I_SRST,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic O_RVALID,
    input wire logic O_FIRST_OUTPUT_PAIR,
    input wire logic O_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // bus and timer properties
    // ****************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SRST);
    sequence s_wr; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY; endsequence
    sequence s_rd; I_ARVALID && O_ARREADY; endsequence
    sequence s_wr_ro; s_wr ##0 I_AWADDR inside {8'h04, 8'h0c, 8'h14}; endsequence
    property p_wr_resp; s_wr |-> ##2 O_BVALID; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    property p_rd_resp; s_rd |=> O_RVALID; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
    property p_ro; s_wr_ro |-> ##2 O_BRESP == tcmp_pkg::RESP_SLVERR; endproperty
    a_ro: assert property (p_ro) else $error("compare write accepted");
    property p_upper; O_RVALID |-> O_RDATA[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper half not zero");
    property p_aw_once; I_AWVALID && O_AWREADY |=> !O_AWREADY; endproperty
    a_aw_once: assert property (p_aw_once) else $error("second write address taken");
    property p_ar_hold; O_RVALID |-> !O_ARREADY; endproperty
    a_ar_hold: assert property (p_ar_hold) else $error("read taken while answering");
    // irq can only drop through a status clear or a mask write
    property p_irq_fall; $fell(O_IRQ) |-> O_BVALID || $past(O_BVALID) || $past(O_BVALID, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
    property p_rst;
        disable iff (1'b0) I_SRST |=> !O_IRQ && !O_BVALID && !O_RVALID && !O_FIRST_OUTPUT_PAIR;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule : timer_compare_double_buffer_checker

// ### verif/timer_compare_double_buffer_test.sv
module timer_compare_double_buffer_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // stimulus and checks
    // ****************
    localparam logic [1:0] OK = tcmp_pkg::RESP_OKAY;
    localparam logic [1:0] ER = tcmp_pkg::RESP_SLVERR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic bready = 1'b0;
    logic arv = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic awrdy, wrdy, bv, arrdy, rv, pair, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_fail = 0;
    int n_checks = 0;
    int hi;
    int ups;
    always #25 clk = ~clk;
    timer_compare_double_buffer i_dut (
        .I_SYS_CLK(clk),
        .I_SRST(rst),
        .I_AWADDR(awaddr),
        .I_AWVALID(awv),
        .O_AWREADY(awrdy),
        .I_WDATA(wdata),
        .I_WSTRB(wstrb),
        .I_WVALID(wv),
        .O_WREADY(wrdy),
        .O_BRESP(bresp),
        .O_BVALID(bv),
        .I_BREADY(bready),
        .I_ARADDR(araddr),
        .I_ARVALID(arv),
        .O_ARREADY(arrdy),
        .O_RDATA(rdata),
        .O_RRESP(rresp),
        .O_RVALID(rv),
        .I_RREADY(rready),
        .O_FIRST_OUTPUT_PAIR(pair),
        .O_IRQ(irq)
    );
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awrdy) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        bready <= 1'b0;
        chk("bresp", bresp, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arrdy) arv <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
        chk("rdata", rdata, ev);
        chk("rresp", rresp, er);
    endtask : rd
    // window of three periods, so counts do not depend on phase
    task automatic meas();
        logic p;
        p = pair;
        hi = 0;
        ups = 0;
        repeat (63) begin
            @(posedge clk);
            if (pair === 1'b1) hi++;
            if (pair === 1'b1 && p !== 1'b1) ups++;
            p = pair;
        end
    endtask : meas
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 11; a++) rd(8'(a * 4), 0, OK);
        rd(8'h2c, 0, ER);
        wr(8'h2c, 32'h00000001, ER);
        for (int a = 1; a < 6; a += 2) begin
            wr(8'(a * 4), 32'h0000ffff, ER);
            rd(8'(a * 4), 0, OK);
        end
        wr(tcmp_pkg::PERIOD_BUF_OFS, 32'habcd0014, OK);
        rd(tcmp_pkg::PERIOD_BUF_OFS, 32'h00000014, OK);
        wstrb <= 4'h2;
        wr(tcmp_pkg::PERIOD_BUF_OFS, 32'h0000ff77, OK);
        rd(tcmp_pkg::PERIOD_BUF_OFS, 32'h0000ff14, OK);
        wr(tcmp_pkg::PERIOD_BUF_OFS, 32'h00000000, OK);
        wstrb <= 4'hf;
        rd(tcmp_pkg::PERIOD_BUF_OFS, 32'h00000014, OK);
        wr(tcmp_pkg::EDGE1_BUF_OFS, 32'h00000005, OK);
        wr(tcmp_pkg::EDGE2_BUF_OFS, 32'h0000000a, OK);
        rd(tcmp_pkg::EDGE1_CMP_OFS, 0, OK);
        wr(tcmp_pkg::LOAD_OFS, 32'h00000001, OK);
        rd(tcmp_pkg::LOAD_OFS, 0, OK);
        rd(tcmp_pkg::PERIOD_CMP_OFS, 32'h00000014, OK);
        rd(tcmp_pkg::EDGE1_CMP_OFS, 32'h00000005, OK);
        rd(tcmp_pkg::EDGE2_CMP_OFS, 32'h0000000a, OK);
        wr(tcmp_pkg::CONTROL_OFS, 32'h00000001, OK);
        repeat (50) @(posedge clk);
        wr(tcmp_pkg::CONTROL_OFS, 0, OK);
        rd(tcmp_pkg::STATUS_OFS, 32'h00000007, OK);
        chk("irq", irq, 0);
        wr(tcmp_pkg::MASK_OFS, 32'h00000002, OK);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1);
        wr(tcmp_pkg::STATUS_OFS, 32'h00000002, OK);
        repeat (2) @(posedge clk);
        chk("irq", irq, 0);
        rd(tcmp_pkg::STATUS_OFS, 32'h00000005, OK);
        wr(tcmp_pkg::CONTROL_OFS, 32'h00000003, OK);
        repeat (25) @(posedge clk);
        meas();
        chk("high", hi, 15);
        chk("rises", ups, 3);
        wr(tcmp_pkg::EDGE2_BUF_OFS, 32'h0000000c, OK);
        rd(tcmp_pkg::EDGE2_CMP_OFS, 32'h0000000a, OK);
        wr(tcmp_pkg::LOAD_OFS, 32'h00000001, OK);
        repeat (25) @(posedge clk);
        rd(tcmp_pkg::LOAD_OFS, 0, OK);
        rd(tcmp_pkg::EDGE2_CMP_OFS, 32'h0000000c, OK);
        meas();
        chk("high", hi, 21);
        wr(tcmp_pkg::CONTROL_OFS, 32'h0000000f, OK);
        meas();
        chk("rises", ups <= 1, 1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("pair", pair, 0);
        rd(tcmp_pkg::EDGE2_CMP_OFS, 0, OK);
        rd(tcmp_pkg::PERIOD_BUF_OFS, 0, OK);
        rd(tcmp_pkg::STATUS_OFS, 0, OK);
        stop_test();
    end
endmodule : timer_compare_double_buffer_test
bind timer_compare_double_buffer timer_compare_double_buffer_checker i_chk (
    .I_SYS_CLK, .I_SRST, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BRESP,
    .O_BVALID, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RVALID, .O_FIRST_OUTPUT_PAIR, .O_IRQ
);
